//--- logic/buck_cfg_pkg.sv
// package: constants and carrier types for the buck configuration and mode select block
// assumes a 250 MHz single clock domain and fuse values that are stable at reset release
`default_nettype none
package buck_cfg_pkg;
  // clock
  localparam int unsigned clk_period_ps = 4000;
  // voltage code layout
  localparam int unsigned vcode_ext_bit = 7;
  localparam logic [7:0] vcode_int_min = 8'h10;
  localparam logic [7:0] vcode_int_max = 8'h6a;
  localparam logic [3:0] vcode_ext_grp_min = 4'h2;
  localparam logic [3:0] vcode_ext_grp_max = 4'hf;
  localparam int unsigned vout_base_mv = 1800;
  localparam int unsigned vout_step_mv = 50;
  localparam int unsigned vout_ext_step_mv = 400;
  localparam int unsigned vout_ext_top_mv = 8000;
  // half frequency threshold: vin/vout above this ratio
  localparam int unsigned half_freq_ratio = 6;
  // on-time figures in ns
  localparam int unsigned min_on_00_ns = 40;
  localparam int unsigned min_on_01_ns = 60;
  localparam int unsigned min_on_10_ns = 80;
  localparam int unsigned min_on_11_ns = 100;
  localparam int unsigned pfm_on_00_ns = 160;
  localparam int unsigned pfm_on_01_ns = 320;
  localparam int unsigned pfm_on_10_ns = 640;
  localparam int unsigned pfm_on_11_ns = 800;
  // cycle counts derived from the clock period
  localparam logic [7:0] min_on_00_cyc = 8'((min_on_00_ns * 1000) / clk_period_ps);
  localparam logic [7:0] min_on_01_cyc = 8'((min_on_01_ns * 1000) / clk_period_ps);
  localparam logic [7:0] min_on_10_cyc = 8'((min_on_10_ns * 1000) / clk_period_ps);
  localparam logic [7:0] min_on_11_cyc = 8'((min_on_11_ns * 1000) / clk_period_ps);
  localparam logic [7:0] pfm_on_00_cyc = 8'((pfm_on_00_ns * 1000) / clk_period_ps);
  localparam logic [7:0] pfm_on_01_cyc = 8'((pfm_on_01_ns * 1000) / clk_period_ps);
  localparam logic [7:0] pfm_on_10_cyc = 8'((pfm_on_10_ns * 1000) / clk_period_ps);
  localparam logic [7:0] pfm_on_11_cyc = 8'((pfm_on_11_ns * 1000) / clk_period_ps);
  // mode field encodings
  localparam logic [1:0] mode_pfm = 2'h0;
  localparam logic [1:0] mode_pwm = 2'h3;
  // reset values
  localparam logic [1:0] mode_reset = 2'h0;
  localparam logic [12:0] vout_mv_reset = 13'h0000;

  typedef struct packed {
    logic [7:0] vout_code;
    logic [1:0] min_on_time;
    logic [1:0] pulse_on_time;
    logic [1:0] default_mode;
    logic pin_function_select;
  } fuse_type;

  typedef struct packed {
    logic ext_divider;
    logic code_valid;
    logic [12:0] vout_mv;
  } vout_type;
endpackage : buck_cfg_pkg
`default_nettype wire

//--- logic/buck_vout_decode.sv
// vout code decoder: divider choice, nominal millivolts, validity
// assumes a static code; purely combinational
`default_nettype none
module buck_vout_decode (
  // code in
  input wire logic [7:0] code_i,
  // decoded out
  output var buck_cfg_pkg::vout_type dec_o
);
  logic [12:0] grp_mv;
  logic [12:0] step_mv;

  always_comb begin
    grp_mv = 13'(buck_cfg_pkg::vout_base_mv)
      + 13'(buck_cfg_pkg::vout_ext_step_mv) * 13'(code_i[6:3] - buck_cfg_pkg::vcode_ext_grp_min);
    step_mv = 13'(buck_cfg_pkg::vout_base_mv)
      + 13'(buck_cfg_pkg::vout_step_mv) * 13'(code_i - buck_cfg_pkg::vcode_int_min);
    dec_o.ext_divider = code_i[buck_cfg_pkg::vcode_ext_bit];
    if (code_i[buck_cfg_pkg::vcode_ext_bit]) begin
      // low three bits ignored
      dec_o.code_valid = (code_i[6:3] >= buck_cfg_pkg::vcode_ext_grp_min);
      dec_o.vout_mv = dec_o.code_valid ? grp_mv : buck_cfg_pkg::vout_mv_reset;
    end else begin
      dec_o.code_valid = (code_i >= buck_cfg_pkg::vcode_int_min)
        && (code_i <= buck_cfg_pkg::vcode_int_max);
      dec_o.vout_mv = dec_o.code_valid ? step_mv : buck_cfg_pkg::vout_mv_reset;
    end
  end
endmodule : buck_vout_decode
`default_nettype wire

//--- logic/buck_config_mode_select.sv
// buck configuration and mode select: fuse decode, on-times, mode choice
// assumes fuse inputs are settled and stable before reset release
`default_nettype none
// Operation
// - output voltage comes from fuse code
// - top bit zero uses internal divider
// - top bit one uses external divider
// - internal codes 1.8 V plus 50 mV steps
// - external codes select 0.4 V ranges
// - min on-time fuse 40/60/80/100 ns
// - ratio above six halves switching frequency
// - pin function zero means sync input
// - sync config uses software mode field
// - mode 00 pulse frequency, 11 pwm
// - pin function one: pin low pwm
// - pulse on-time fuse 160/320/640/800 ns
module buck_config_mode_select (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // fuse store
  input wire buck_cfg_pkg::fuse_type fuse_i,
  // software mode field
  input wire logic sw_mode_wr_i,
  input wire logic [1:0] sw_mode_wdata_i,
  // pins and analog comparator
  input wire logic shared_mode_sync_pin_i,
  input wire logic ratio_above_limit_i,
  // decoded configuration
  output logic ext_divider_o,
  output logic vout_code_valid_o,
  output logic [7:0] fuse_vout_code_o,
  output logic [12:0] vout_mv_o,
  output logic [7:0] min_on_cycles_o,
  output logic [7:0] pulse_on_cycles_o,
  // mode
  output logic [1:0] sw_switching_mode_field_o,
  output logic pulse_frequency_mode_o,
  output logic sync_input_enable_o,
  output logic half_freq_o,
  output logic config_loaded_o
);
  typedef enum logic {st_load = 1'b0, st_run = 1'b1} phase_type;

  phase_type phase_reg, phase_next;
  buck_cfg_pkg::fuse_type fuse_reg, fuse_next;
  buck_cfg_pkg::vout_type vout_reg, vout_next;
  buck_cfg_pkg::vout_type dec;
  logic [7:0] min_on_reg, min_on_next;
  logic [7:0] pulse_on_reg, pulse_on_next;
  logic [1:0] mode_reg, mode_next;
  logic pfm_reg, pfm_next;
  logic half_reg, half_next;
  logic sync_en_reg, sync_en_next;
  logic [1:0] pin_sync_reg, pin_sync_next;
  logic [1:0] ratio_sync_reg, ratio_sync_next;
  logic mode_wr_ok;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] min_on_lookup(input logic [1:0] sel);
    unique case (sel)
      2'h0: min_on_lookup = buck_cfg_pkg::min_on_00_cyc;
      2'h1: min_on_lookup = buck_cfg_pkg::min_on_01_cyc;
      2'h2: min_on_lookup = buck_cfg_pkg::min_on_10_cyc;
      2'h3: min_on_lookup = buck_cfg_pkg::min_on_11_cyc;
    endcase
  endfunction : min_on_lookup

  function automatic logic [7:0] pulse_on_lookup(input logic [1:0] sel);
    unique case (sel)
      2'h0: pulse_on_lookup = buck_cfg_pkg::pfm_on_00_cyc;
      2'h1: pulse_on_lookup = buck_cfg_pkg::pfm_on_01_cyc;
      2'h2: pulse_on_lookup = buck_cfg_pkg::pfm_on_10_cyc;
      2'h3: pulse_on_lookup = buck_cfg_pkg::pfm_on_11_cyc;
    endcase
  endfunction : pulse_on_lookup

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  // only the second stage is read; the first may still be settling
  always_comb begin
    pin_sync_next = {pin_sync_reg[0], shared_mode_sync_pin_i};
    ratio_sync_next = {ratio_sync_reg[0], ratio_above_limit_i};
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_sync_reg <= 2'h0;
      ratio_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= pin_sync_next;
      ratio_sync_reg <= ratio_sync_next;
    end
  end

  // ---------------------------------------------------------------
  // fuse capture
  // ---------------------------------------------------------------
  // fuses caught once, one edge after reset release; later moves are ignored
  always_comb begin
    phase_next = phase_reg;
    fuse_next = fuse_reg;
    sync_en_next = sync_en_reg;
    unique case (phase_reg)
      st_load: begin
        fuse_next = fuse_i;
        sync_en_next = !fuse_i.pin_function_select;
        phase_next = st_run;
      end
      st_run: begin
        phase_next = st_run;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= st_load;
      fuse_reg <= '0;
      sync_en_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      fuse_reg <= fuse_next;
      sync_en_reg <= sync_en_next;
    end
  end

  // ---------------------------------------------------------------
  // voltage code and on-time decode
  // ---------------------------------------------------------------
  buck_vout_decode u_decode (
    .code_i(fuse_reg.vout_code),
    .dec_o(dec)
  );

  // settles one edge after capture, from the registered fuse copy
  always_comb begin
    vout_next = vout_reg;
    min_on_next = min_on_reg;
    pulse_on_next = pulse_on_reg;
    if (phase_reg == st_run) begin
      vout_next = dec;
      min_on_next = min_on_lookup(fuse_reg.min_on_time);
      pulse_on_next = pulse_on_lookup(fuse_reg.pulse_on_time);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vout_reg <= '0;
      min_on_reg <= 8'h00;
      pulse_on_reg <= 8'h00;
    end else begin
      vout_reg <= vout_next;
      min_on_reg <= min_on_next;
      pulse_on_reg <= pulse_on_next;
    end
  end

  // ---------------------------------------------------------------
  // switching mode
  // ---------------------------------------------------------------
  // reserved write codes are refused, but a 01 or 10 default_mode fuse still loads into the field
  assign mode_wr_ok = sw_mode_wr_i && (sw_mode_wdata_i == buck_cfg_pkg::mode_pfm
    || sw_mode_wdata_i == buck_cfg_pkg::mode_pwm);

  always_comb begin
    mode_next = mode_reg;
    pfm_next = pfm_reg;
    half_next = ratio_sync_reg[1];
    unique case (phase_reg)
      st_load: begin
        mode_next = fuse_i.default_mode;
      end
      st_run: begin
        if (mode_wr_ok) begin
          mode_next = sw_mode_wdata_i;
        end
        // pin mode: field still follows writes but no longer steers the mode
        if (fuse_reg.pin_function_select) begin
          pfm_next = pin_sync_reg[1];
        end else begin
          pfm_next = (mode_reg == buck_cfg_pkg::mode_pfm);
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= buck_cfg_pkg::mode_reset;
      pfm_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      pfm_reg <= pfm_next;
      half_reg <= half_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    ext_divider_o = vout_reg.ext_divider;
    vout_code_valid_o = vout_reg.code_valid;
    vout_mv_o = vout_reg.vout_mv;
    fuse_vout_code_o = fuse_reg.vout_code;
    min_on_cycles_o = min_on_reg;
    pulse_on_cycles_o = pulse_on_reg;
    sw_switching_mode_field_o = mode_reg;
    pulse_frequency_mode_o = pfm_reg;
    sync_input_enable_o = sync_en_reg;
    half_freq_o = half_reg;
    config_loaded_o = (phase_reg == st_run);
  end
endmodule : buck_config_mode_select
`default_nettype wire

//--- tb/buck_cfg_properties.sv
// checker: port-level timing and decode properties of the buck config block
// assumes fuses stay still after reset release; bound to the top module
`default_nettype none
module buck_cfg_properties (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // inputs
  input wire buck_cfg_pkg::fuse_type fuse_i,
  input wire logic sw_mode_wr_i,
  input wire logic [1:0] sw_mode_wdata_i,
  input wire logic shared_mode_sync_pin_i,
  input wire logic ratio_above_limit_i,
  // outputs
  input wire logic ext_divider_o,
  input wire logic [12:0] vout_mv_o,
  input wire logic [7:0] min_on_cycles_o,
  input wire logic [7:0] pulse_on_cycles_o,
  input wire logic [1:0] sw_switching_mode_field_o,
  input wire logic pulse_frequency_mode_o,
  input wire logic sync_input_enable_o,
  input wire logic half_freq_o,
  input wire logic config_loaded_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [7:0] c = fuse_i.vout_code;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  divider_sel_a: assert property ($past(config_loaded_o)
    |-> ext_divider_o == c[7]) else $error("divider select wrong");
  int_vout_a: assert property ($past(config_loaded_o) && c >= 8'h10 && c <= 8'h6a
    |-> vout_mv_o == 13'h708 + (c - 8'h10) * 13'h32) else $error("internal vout wrong");
  ext_vout_a: assert property ($past(config_loaded_o) && c[7] && c[6:3] >= 4'h2
    |-> vout_mv_o == 13'h708 + (c[6:3] - 4'h2) * 13'h190) else $error("external vout wrong");
  on_times_a: assert property ($past(config_loaded_o)
    |-> min_on_cycles_o == 8'ha + 8'h5 * fuse_i.min_on_time && pulse_on_cycles_o ==
    (fuse_i.pulse_on_time == 2'h3 ? 8'hc8 : 8'h28 << fuse_i.pulse_on_time)) else $error("on time");
  mode_write_a: assert property (config_loaded_o && sw_mode_wr_i
    && sw_mode_wdata_i inside {2'h0, 2'h3} |=> sw_switching_mode_field_o == $past(sw_mode_wdata_i))
    else $error("mode write lost");
  mode_hold_a: assert property (config_loaded_o
    && !(sw_mode_wr_i && sw_mode_wdata_i inside {2'h0, 2'h3}) |=> $stable(sw_switching_mode_field_o))
    else $error("mode field moved");
  reg_mode_a: assert property ($past(config_loaded_o) && !fuse_i.pin_function_select
    |-> pulse_frequency_mode_o == ($past(sw_switching_mode_field_o) == 2'h0)) else $error("reg mode");
  pin_mode_a: assert property ((config_loaded_o && fuse_i.pin_function_select
    && $stable(shared_mode_sync_pin_i)) [*4] |-> pulse_frequency_mode_o == shared_mode_sync_pin_i)
    else $error("pin mode");
  half_freq_a: assert property ((config_loaded_o && $stable(ratio_above_limit_i)) [*4]
    |-> half_freq_o == ratio_above_limit_i) else $error("half freq");
  sync_pin_a: assert property (config_loaded_o
    |-> sync_input_enable_o == !fuse_i.pin_function_select) else $error("sync enable");
endmodule : buck_cfg_properties
bind buck_config_mode_select buck_cfg_properties i_props (.*);
`default_nettype wire

//--- tb/buck_far_model.sv
// far side model: fuse store, mode pin, ratio comparator and host writes
// assumes calls come from one bench process just after a clock edge
`default_nettype none
module buck_far_model (
  // clock
  input wire logic mclk_i,
  // toward the block
  output var buck_cfg_pkg::fuse_type fuse_o,
  output var logic wr_o,
  output var logic [1:0] wdata_o,
  output var logic pin_o,
  output var logic ratio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {fuse_o, wr_o, wdata_o, pin_o, ratio_o} = '0;
  // fuses are only moved while the block is held in reset
  task automatic setup(input buck_cfg_pkg::fuse_type f, input logic p, r);
    fuse_o <= f;
    pin_o <= p;
    ratio_o <= r;
  endtask : setup
  // one-edge strobe; data inverted after release, so a stale 00 or 11 still reads as the other valid code
  task automatic write_mode(input logic [1:0] d);
    // host keeps off the field while the pin owns the mode
    wr_o <= !fuse_o.pin_function_select;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : write_mode
endmodule : buck_far_model
`default_nettype wire

//--- tb/buck_config_mode_select_tb.sv
// bench: random fuse sets, mode writes and pin changes with queued expectations
// assumes the far model and checker files are compiled before this one
`default_nettype none
module buck_config_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic ext, vld, pfq, syn, half;
    logic [12:0] mv;
    logic [7:0] code, mn, pl;
    logic [1:0] fld;
  } exp_type;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  buck_cfg_pkg::fuse_type fuse, f;
  logic wr, pin, ratio, ext, vld, pfq, syn, half, ld;
  logic [1:0] wd, m, cur, fld;
  logic [12:0] mv;
  logic [7:0] code, mn, pl;
  exp_type e;
  exp_type q[$];
  event chk;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 77516;
  logic [7:0] dir[7] = '{8'h10, 8'h6a, 8'h6b, 8'h0f, 8'h90, 8'hf8, 8'h88};
  logic [7:0] pt[4] = '{8'h28, 8'h50, 8'ha0, 8'hc8};
  always #2 mclk_i = ~mclk_i;
  buck_far_model i_far (.mclk_i(mclk_i), .fuse_o(fuse), .wr_o(wr), .wdata_o(wd),
    .pin_o(pin), .ratio_o(ratio));
  buck_config_mode_select i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fuse_i(fuse),
    .sw_mode_wr_i(wr), .sw_mode_wdata_i(wd), .shared_mode_sync_pin_i(pin),
    .ratio_above_limit_i(ratio), .ext_divider_o(ext), .vout_code_valid_o(vld),
    .fuse_vout_code_o(code), .vout_mv_o(mv), .min_on_cycles_o(mn), .pulse_on_cycles_o(pl),
    .sw_switching_mode_field_o(fld), .pulse_frequency_mode_o(pfq), .sync_input_enable_o(syn),
    .half_freq_o(half), .config_loaded_o(ld));
  // ----------------------------------------
  // expectation, compare and verdict
  // ----------------------------------------
  task automatic note(input logic [1:0] md);
    exp_type x;
    x.code = f.vout_code;
    x.ext = x.code[7];
    x.vld = x.ext ? x.code[6:3] >= 4'h2 : x.code >= 8'h10 && x.code <= 8'h6a;
    x.mv = !x.vld ? 13'h0 : x.ext ? 13'h708 + (x.code[6:3] - 4'h2) * 13'h190
      : 13'h708 + (x.code - 8'h10) * 13'h32;
    x.mn = 8'ha + 8'h5 * f.min_on_time;
    x.pl = pt[f.pulse_on_time];
    x.fld = md;
    x.pfq = f.pin_function_select ? pin : md == 2'h0;
    x.syn = !f.pin_function_select;
    x.half = ratio;
    q.push_back(x);
    -> chk;
  endtask : note
  task automatic cmp(input string n, input logic [12:0] x, g);
    n_tests++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : cmp
  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial forever begin
    @chk;
    @(negedge mclk_i);
    e = q.pop_front();
    cmp("code", e.code, code);
    cmp("divider", e.ext, ext);
    cmp("valid", e.vld, vld);
    cmp("vout", e.mv, mv);
    cmp("min on", e.mn, mn);
    cmp("pulse on", e.pl, pl);
    cmp("field", e.fld, fld);
    cmp("pulse mode", e.pfq, pfq);
    cmp("sync", e.syn, syn);
    cmp("half", e.half, half);
    cmp("loaded", 13'h1, ld);
  end
  // ----------------------------------------
  // stimulus; short resets after the first keep the run brief
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 60; i++) begin
      f = 15'($random(seed));
      if (i < 7) f.vout_code = dir[i];
      f.default_mode = {2{f.default_mode[0]}};
      rst_n_i <= 1'b0;
      i_far.setup(f, 1'($random(seed)), 1'($random(seed)));
      repeat (i == 0 ? 20 : 2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      cur = f.default_mode;
      note(cur);
      m = 2'($random(seed));
      i_far.write_mode(m);
      if ((m == 2'h0 || m == 2'h3) && !f.pin_function_select) cur = m;
      repeat (3) @(posedge mclk_i);
      note(cur);
      i_far.setup(f, !pin, !ratio);
      repeat (5) @(posedge mclk_i);
      note(cur);
      // let the compare land before the next reset clears the outputs
      @(posedge mclk_i);
    end
    repeat (2) @(posedge mclk_i);
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_errors++;
    finish_test();
  end
endmodule : buck_config_mode_select_tb
`default_nettype wire
